/* File: rtl/gta_aux_timers.sv */
// two identical 16-bit auxiliary timers working beside a core timer
// assumes core timer logic on the same clock supplies its count, its
// hardware over/underflow pulse and its toggle latch level; pins async
module gta_aux_timers
    import gta_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic [AW-1:0] avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic          aux_a_input_pin,
    input  wire logic          aux_b_input_pin,
    input  wire logic          aux_a_ext_direction_pin,
    input  wire logic          aux_b_ext_direction_pin,
    input  wire logic [TW-1:0] core_count,
    input  wire logic          core_overflow,
    input  wire logic          core_toggle_latch,
    output logic               core_reload,
    output logic [TW-1:0]      core_reload_value,
    output logic               core_irq_set,
    output logic               aux_a_irq_req,
    output logic               aux_b_irq_req
);

    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic rise,
                                      input logic fall);
        case (sel)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_ANY:  edge_hit = rise | fall;
            default:   edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // shared write decode
    logic [15:0]       wmask;
    logic [15:0]       wval;
    logic [1:0]        wr_ctl;
    logic [1:0]        wr_cnt;
    logic [1:0]        wr_ic;

    assign wmask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wval   = avs_writedata[15:0];
    assign wr_ctl = {avs_write && avs_address == OFS_CTL_B,
                     avs_write && avs_address == OFS_CTL_A};
    assign wr_cnt = {avs_write && avs_address == OFS_CNT_B,
                     avs_write && avs_address == OFS_CNT_A};
    assign wr_ic  = {avs_write && avs_address == OFS_IC_B,
                     avs_write && avs_address == OFS_IC_A};

    // hardware toggle-latch transitions only; software writes never pulse
    logic otl_rise;
    logic otl_fall;
    assign otl_rise = core_overflow & ~core_toggle_latch;
    assign otl_fall = core_overflow &  core_toggle_latch;

    // free-running prescaler
    logic [PW-1:0] pre_r;
    logic [PW-1:0] pre_nxt;

    always_comb begin
        pre_nxt = pre_r + PW'(1);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pre_r <= PRESC_RESET;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    logic [1:0]          in_pin;
    logic [1:0]          dir_pin;
    logic [1:0][TW-1:0]  cnt_q;
    logic [1:0][15:0]    ctl_q;
    logic [1:0]          flag_q;
    logic [1:0]          ie_q;
    logic [1:0]          step_q;
    logic [1:0]          reload_trig;
    logic [1:0]          reload_latch;
    logic [1:0]          cap_evt_q;
    logic [1:0]          tick_q;

    assign in_pin  = {aux_b_input_pin, aux_a_input_pin};
    assign dir_pin = {aux_b_ext_direction_pin, aux_a_ext_direction_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            logic [2:0]    in_sync_r;
            logic [2:0]    in_sync_nxt;
            logic [1:0]    dir_sync_r;
            logic [1:0]    dir_sync_nxt;
            logic [15:0]   ctl_r;
            logic [15:0]   ctl_nxt;
            logic [TW-1:0] cnt_r;
            logic [TW-1:0] cnt_nxt;
            logic          flag_r;
            logic          flag_nxt;
            logic          ie_r;
            logic          ie_nxt;
            gta_mode_t     mode;
            logic [2:0]    sel;
            logic          pin_lvl;
            logic          pin_rise;
            logic          pin_fall;
            logic          cnt_evt;
            logic          cap_evt;
            logic          down;
            logic [9:0]    pmask;
            logic          tick;
            logic          step;
            logic          wrap;
            logic          irq_set;

            // two stages, then a third for edge compare
            always_comb begin
                in_sync_nxt  = {in_sync_r[1:0], in_pin[gi]};
                dir_sync_nxt = {dir_sync_r[0], dir_pin[gi]};
            end

            always_comb begin
                mode     = gta_mode_t'(ctl_r[MODE_LSB +: 3]);
                sel      = ctl_r[SEL_LSB +: 3];
                pin_lvl  = in_sync_r[1];
                pin_rise =  in_sync_r[1] & ~in_sync_r[2];
                pin_fall = ~in_sync_r[1] &  in_sync_r[2];
                // sel[2] picks latch over pin; X00 none
                cnt_evt  = sel[2] ? edge_hit(sel[1:0], otl_rise, otl_fall)
                                  : edge_hit(sel[1:0], pin_rise, pin_fall);
                cap_evt  = edge_hit(sel[1:0], pin_rise, pin_fall);
                down     = ctl_r[UDE_BIT] ? (dir_sync_r[1] ^ ctl_r[UD_BIT])
                                          : ctl_r[UD_BIT];
                pmask    = 10'((PRESC_BASE << sel) - PRESC_ONE);
                tick     = (pre_r & pmask) == pmask;
                case (mode)
                    MODE_TIMER:   step = tick;
                    MODE_GATE_LO: step = tick & ~pin_lvl;
                    MODE_GATE_HI: step = tick &  pin_lvl;
                    MODE_COUNTER: step = cnt_evt;
                    default:      step = 1'b0;
                endcase
                step     = step & ctl_r[RUN_BIT];
                wrap     = down ? (cnt_r == CNT_RESET)
                                : (cnt_r == CNT_MAX);
            end

            always_comb begin
                ctl_nxt  = ctl_r;
                cnt_nxt  = cnt_r;
                ie_nxt   = ie_r;
                irq_set  = 1'b0;
                if (wr_ctl[gi]) begin
                    ctl_nxt = ((ctl_r & ~wmask) | (wval & wmask)) & CTL_MASK;
                end
                // software write wins over any count or capture
                if (wr_cnt[gi]) begin
                    cnt_nxt = (cnt_r & ~wmask) | (wval & wmask);
                end else if (mode == MODE_CAPTURE && cap_evt) begin
                    cnt_nxt = core_count;
                end else if (step) begin
                    // independent direction even when chained
                    cnt_nxt = down ? cnt_r - CNT_ONE
                                   : cnt_r + CNT_ONE;
                end
                if (step && wrap) begin
                    irq_set = 1'b1;
                end
                if (mode == MODE_RELOAD && cnt_evt) begin
                    irq_set = 1'b1;
                end
                if (mode == MODE_CAPTURE && cap_evt) begin
                    irq_set = 1'b1;
                end
                flag_nxt = flag_r;
                if (wr_ic[gi] && avs_byteenable[0]) begin
                    flag_nxt = wval[IR_BIT];
                    ie_nxt   = wval[IE_BIT];
                end
                // hardware set beats software clear
                flag_nxt = flag_nxt | irq_set;
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    in_sync_r  <= 3'h0;
                    dir_sync_r <= 2'h0;
                    ctl_r      <= CTL_RESET;
                    cnt_r      <= CNT_RESET;
                    flag_r     <= 1'b0;
                    ie_r       <= 1'b0;
                end else begin
                    in_sync_r  <= in_sync_nxt;
                    dir_sync_r <= dir_sync_nxt;
                    ctl_r      <= ctl_nxt;
                    cnt_r      <= cnt_nxt;
                    flag_r     <= flag_nxt;
                    ie_r       <= ie_nxt;
                end
            end

            assign cnt_q[gi]        = cnt_r;
            assign ctl_q[gi]        = ctl_r;
            assign flag_q[gi]       = flag_r;
            assign ie_q[gi]         = ie_r;
            assign step_q[gi]       = step;
            assign tick_q[gi]       = tick;
            assign cap_evt_q[gi]    = mode == MODE_CAPTURE && cap_evt;
            assign reload_trig[gi]  = mode == MODE_RELOAD && cnt_evt;
            assign reload_latch[gi] = sel[2];
        end
    endgenerate

    assign aux_a_irq_req = flag_q[0] & ie_q[0];
    assign aux_b_irq_req = flag_q[1] & ie_q[1];

    // reload path toward the core timer
    logic          rl_r;
    logic          rl_nxt;
    logic [TW-1:0] rlv_r;
    logic [TW-1:0] rlv_nxt;
    logic          cirq_r;
    logic          cirq_nxt;

    always_comb begin
        rl_nxt   = |reload_trig;
        rlv_nxt  = rlv_r;
        if (reload_trig[1]) begin
            rlv_nxt = cnt_q[1];
        end else if (reload_trig[0]) begin
            rlv_nxt = cnt_q[0];
        end
        cirq_nxt = |(reload_trig & reload_latch);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rl_r   <= 1'b0;
            rlv_r  <= CNT_RESET;
            cirq_r <= 1'b0;
        end else begin
            rl_r   <= rl_nxt;
            rlv_r  <= rlv_nxt;
            cirq_r <= cirq_nxt;
        end
    end

    assign core_reload       = rl_r;
    assign core_reload_value = rlv_r;
    assign core_irq_set      = cirq_r;

    // bus slave: writes take no wait, reads one wait state
    logic        rd_ack_r;
    logic        rd_ack_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    always_comb begin
        rd_ack_nxt = avs_read & ~rd_ack_r;
        rdata_nxt  = rdata_r;
        if (avs_read && !rd_ack_r) begin
            case (avs_address)
                OFS_CTL_A: rdata_nxt = {16'h0000, ctl_q[0]};
                OFS_CTL_B: rdata_nxt = {16'h0000, ctl_q[1]};
                OFS_CNT_A: rdata_nxt = {16'h0000, cnt_q[0]};
                OFS_CNT_B: rdata_nxt = {16'h0000, cnt_q[1]};
                // place each bit by index so no shift width is lost
                OFS_IC_A: begin
                    rdata_nxt         = 32'h00000000;
                    rdata_nxt[IR_BIT] = flag_q[0];
                    rdata_nxt[IE_BIT] = ie_q[0];
                end
                OFS_IC_B: begin
                    rdata_nxt         = 32'h00000000;
                    rdata_nxt[IR_BIT] = flag_q[1];
                    rdata_nxt[IE_BIT] = ie_q[1];
                end
                default:   rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_ack_r <= 1'b0;
            rdata_r  <= 32'h00000000;
        end else begin
            rd_ack_r <= rd_ack_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign avs_waitrequest = avs_read & ~rd_ack_r;
    assign avs_readdata    = rdata_r;

    // checks
    a_reload_b_wins: assert property (@(posedge clock) disable iff (rst)
        (&reload_trig) |=> core_reload_value == $past(cnt_q[1]))
        else $error("reload value not taken from second timer");

    a_reload_pulse: assert property (@(posedge clock) disable iff (rst)
        reload_trig[0] |=> core_reload && flag_q[0])
        else $error("reload trigger gave no reload or flag");

    a_hold_in_reload: assert property (@(posedge clock) disable iff (rst)
        (ctl_q[0][MODE_LSB +: 3] == MODE_RELOAD && !wr_cnt[0])
        |=> $stable(cnt_q[0]))
        else $error("timer counted in reload mode");

    a_stop_when_idle: assert property (@(posedge clock) disable iff (rst)
        (!ctl_q[1][RUN_BIT] && !wr_cnt[1] && !cap_evt_q[1])
        |=> $stable(cnt_q[1]))
        else $error("timer counted with run flag clear");

    a_overflow_flag: assert property (@(posedge clock) disable iff (rst)
        (step_q[0] && !wr_cnt[0] && !ctl_q[0][UDE_BIT]
         && !ctl_q[0][UD_BIT] && cnt_q[0] == CNT_MAX)
        |=> cnt_q[0] == CNT_RESET && flag_q[0])
        else $error("overflow did not wrap and flag");

    a_capture_core: assert property (@(posedge clock) disable iff (rst)
        (cap_evt_q[1] && !wr_cnt[1])
        |=> cnt_q[1] == $past(core_count) && flag_q[1])
        else $error("capture missed core count");

    a_latch_core_irq: assert property (@(posedge clock) disable iff (rst)
        (reload_trig[1] && reload_latch[1]) |=> core_irq_set)
        else $error("latch reload did not flag core timer");

    a_no_sw_latch: assert property (@(posedge clock) disable iff (rst)
        (!core_overflow && reload_latch[0] && !wr_cnt[0]
         && ctl_q[0][MODE_LSB +: 3] == MODE_COUNTER)
        |=> $stable(cnt_q[0]))
        else $error("count without hardware latch toggle");

    a_prescale_rate: assert property (@(posedge clock) disable iff (rst)
        (ctl_q[0][SEL_LSB +: 3] == 3'h0 && tick_q[0])
        |-> pre_r[2:0] == 3'h7)
        else $error("prescaler tick off its period");

endmodule : gta_aux_timers

/* File: rtl/gta_pkg.sv */
// package for the two auxiliary timers beside the core timer
// assumes a 32-bit Avalon-MM slave port and a single system clock
package gta_pkg;

    localparam int          TW          = 16;
    localparam int          AW          = 5;
    localparam int          PW          = 10;

    // register byte offsets
    localparam logic [4:0]  OFS_CTL_A   = 5'h00;
    localparam logic [4:0]  OFS_CTL_B   = 5'h04;
    localparam logic [4:0]  OFS_CNT_A   = 5'h08;
    localparam logic [4:0]  OFS_CNT_B   = 5'h0C;
    localparam logic [4:0]  OFS_IC_A    = 5'h10;
    localparam logic [4:0]  OFS_IC_B    = 5'h14;

    // control register fields
    localparam int          SEL_LSB     = 0;
    localparam int          MODE_LSB    = 3;
    localparam int          RUN_BIT     = 6;
    localparam int          UD_BIT      = 7;
    localparam int          UDE_BIT     = 8;
    localparam logic [15:0] CTL_MASK    = 16'h01FF;
    localparam logic [15:0] CTL_RESET   = 16'h0000;
    localparam logic [15:0] CNT_RESET   = 16'h0000;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [15:0] CNT_ONE     = 16'h0001;

    // interrupt control register fields
    localparam int          IE_BIT      = 6;
    localparam int          IR_BIT      = 7;

    // prescaler: factor 8 * 2^sel
    localparam logic [10:0] PRESC_BASE  = 11'h008;
    localparam logic [10:0] PRESC_ONE   = 11'h001;
    localparam logic [9:0]  PRESC_RESET = 10'h000;

    typedef enum logic [2:0] {
        MODE_TIMER   = 3'h0,
        MODE_COUNTER = 3'h1,
        MODE_GATE_LO = 3'h2,
        MODE_GATE_HI = 3'h3,
        MODE_RELOAD  = 3'h4,
        MODE_CAPTURE = 3'h5
    } gta_mode_t;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_ANY  = 2'h3
    } gta_edge_t;

endpackage : gta_pkg

/* File: tb/gta_pin_model.sv */
// partner model: external count, gate and direction pins of both timers
// assumes the bench calls its tasks from one process, after a clock edge
module gta_pin_model (
    input  wire logic clock,
    output logic      aux_a_input_pin,
    output logic      aux_b_input_pin,
    output logic      aux_a_ext_direction_pin,
    output logic      aux_b_ext_direction_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        aux_a_input_pin         = 1'b0;
        aux_b_input_pin         = 1'b0;
        aux_a_ext_direction_pin = 1'b0;
        aux_b_ext_direction_pin = 1'b0;
    end

    // each level held eight clocks so the edge is seen
    task automatic hold_level(input logic sel_b, input logic lvl);
        @(posedge clock);
        if (sel_b) aux_b_input_pin <= lvl;
        else aux_a_input_pin <= lvl;
        repeat (8) @(posedge clock);
    endtask : hold_level

    task automatic pulse(input logic sel_b);
        hold_level(sel_b, 1'b1);
        hold_level(sel_b, 1'b0);
    endtask : pulse

    task automatic set_dir(input logic sel_b, input logic lvl);
        @(posedge clock);
        if (sel_b) aux_b_ext_direction_pin <= lvl;
        else aux_a_ext_direction_pin <= lvl;
        repeat (8) @(posedge clock);
    endtask : set_dir
endmodule : gta_pin_model

/* File: tb/tb.sv */
// self-checking bench for the two auxiliary timers
// assumes pins come from the partner model, core link driven here
module tb;
    import gta_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic          clock, rst;
    logic [AW-1:0] avs_address;
    logic          avs_read, avs_write;
    logic [31:0]   avs_writedata, avs_readdata;
    logic [3:0]    avs_byteenable;
    logic          avs_waitrequest;
    logic          pin_a, pin_b, dir_a, dir_b;
    logic [TW-1:0] core_count, core_reload_value;
    logic          core_overflow, core_toggle_latch;
    logic          core_reload, core_irq_set;
    logic          aux_a_irq_req, aux_b_irq_req;
    int            fails, n_checks;

    gta_aux_timers dut (
        .clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .aux_a_input_pin(pin_a), .aux_b_input_pin(pin_b),
        .aux_a_ext_direction_pin(dir_a), .aux_b_ext_direction_pin(dir_b),
        .core_count(core_count), .core_overflow(core_overflow),
        .core_toggle_latch(core_toggle_latch), .core_reload(core_reload),
        .core_reload_value(core_reload_value),
        .core_irq_set(core_irq_set), .aux_a_irq_req(aux_a_irq_req),
        .aux_b_irq_req(aux_b_irq_req));

    gta_pin_model pins (
        .clock(clock), .aux_a_input_pin(pin_a), .aux_b_input_pin(pin_b),
        .aux_a_ext_direction_pin(dir_a), .aux_b_ext_direction_pin(dir_b));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one bus cycle; waitrequest and readdata taken at the rising edge
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        q = 16'h0000;
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= {16'h0000, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) check(16'h0BAD, 16'h0000);
        q = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, q);
        check(q, exp);
    endtask : rd_chk

    // core over/underflow with the latch level before it toggles
    task automatic ovf(input logic lvl);
        @(posedge clock);
        core_overflow     <= 1'b1;
        core_toggle_latch <= lvl;
        @(posedge clock);
        core_overflow     <= 1'b0;
        core_toggle_latch <= ~lvl;
    endtask : ovf

    task automatic t_reset;
        rd_chk(OFS_CTL_A, 16'h0000);
        rd_chk(OFS_CNT_B, 16'h0000);
        rd_chk(OFS_IC_A, 16'h0000);
        wr(5'h18, 16'h5A5A);
        rd_chk(5'h18, 16'h0000);
        wr(OFS_CTL_A, 16'hFFE7);
        rd_chk(OFS_CTL_A, 16'h01E7);
        avs_byteenable <= 4'h2;
        wr(OFS_CNT_B, 16'hA5C3);
        avs_byteenable <= 4'hF;
        rd_chk(OFS_CNT_B, 16'hA500);
        $display("test reset done");
    endtask : t_reset

    task automatic t_timer;
        logic [15:0] q;
        wr(OFS_CNT_A, 16'h0000);
        wr(OFS_CTL_A, 16'h0040);
        repeat (79) @(posedge clock);
        wr(OFS_CTL_A, 16'h0000);
        bus(1'b0, OFS_CNT_A, 16'h0000, q);
        check(16'(q >= 9 && q <= 11), 16'h0001);
        $display("test timer done");
    endtask : t_timer

    task automatic t_counter;
        wr(OFS_CNT_A, 16'h0005);
        pins.set_dir(1'b0, 1'b1);
        wr(OFS_CTL_A, 16'h0149);
        pins.pulse(1'b0);
        pins.pulse(1'b0);
        rd_chk(OFS_CNT_A, 16'h0003);
        wr(OFS_CTL_A, 16'h01C9);
        pins.pulse(1'b0);
        pins.pulse(1'b0);
        rd_chk(OFS_CNT_A, 16'h0005);
        pins.set_dir(1'b0, 1'b0);
        wr(OFS_CNT_A, 16'h0000);
        wr(OFS_CTL_A, 16'h00C9);
        pins.pulse(1'b0);
        rd_chk(OFS_CNT_A, 16'hFFFF);
        rd_chk(OFS_IC_A, 16'h0080);
        check(16'(aux_a_irq_req), 16'h0000);
        wr(OFS_CTL_A, 16'h0089);
        pins.pulse(1'b0);
        rd_chk(OFS_CNT_A, 16'hFFFF);
        wr(OFS_CTL_A, 16'h0049);
        pins.pulse(1'b0);
        rd_chk(OFS_CNT_A, 16'h0000);
        wr(OFS_CNT_B, 16'h0010);
        pins.set_dir(1'b1, 1'b1);
        wr(OFS_CTL_B, 16'h014B);
        pins.pulse(1'b1);
        rd_chk(OFS_CNT_B, 16'h000E);
        pins.set_dir(1'b1, 1'b0);
        $display("test counter done");
    endtask : t_counter

    task automatic t_gate;
        logic [15:0] q;
        wr(OFS_CNT_B, 16'h0000);
        wr(OFS_CTL_B, 16'h0058);
        repeat (40) @(posedge clock);
        rd_chk(OFS_CNT_B, 16'h0000);
        pins.hold_level(1'b1, 1'b1);
        repeat (32) @(posedge clock);
        pins.hold_level(1'b1, 1'b0);
        bus(1'b0, OFS_CNT_B, 16'h0000, q);
        check(16'(q >= 5 && q <= 6), 16'h0001);
        wr(OFS_CTL_B, 16'h0050);
        wr(OFS_CNT_B, 16'h0000);
        repeat (40) @(posedge clock);
        bus(1'b0, OFS_CNT_B, 16'h0000, q);
        check(16'(q >= 5 && q <= 6), 16'h0001);
        $display("test gate done");
    endtask : t_gate

    task automatic t_chain;
        wr(OFS_CNT_A, 16'h0000);
        wr(OFS_CTL_A, 16'h004F);
        for (int i = 0; i < 4; i++) ovf(i[0]);
        rd_chk(OFS_CNT_A, 16'h0004);
        wr(OFS_CTL_A, 16'h004D);
        for (int i = 0; i < 4; i++) ovf(i[0]);
        rd_chk(OFS_CNT_A, 16'h0006);
        $display("test chain done");
    endtask : t_chain

    task automatic t_reload;
        wr(OFS_IC_B, 16'h0000);
        wr(OFS_CNT_A, 16'h5555);
        wr(OFS_CNT_B, 16'h1234);
        wr(OFS_CTL_A, 16'h0067);
        wr(OFS_CTL_B, 16'h0067);
        ovf(1'b0);
        @(negedge clock);
        check(16'(core_reload), 16'h0001);
        check(core_reload_value, 16'h1234);
        check(16'(core_irq_set), 16'h0001);
        rd_chk(OFS_CNT_B, 16'h1234);
        rd_chk(OFS_IC_B, 16'h0080);
        check(16'(aux_b_irq_req), 16'h0000);
        wr(OFS_IC_B, 16'h00C0);
        @(negedge clock);
        check(16'(aux_b_irq_req), 16'h0001);
        $display("test reload done");
    endtask : t_reload

    task automatic t_capture;
        wr(OFS_CTL_A, 16'h006D);
        core_count <= 16'hABCD;
        pins.pulse(1'b0);
        core_count <= 16'h0000;
        rd_chk(OFS_CNT_A, 16'hABCD);
        wr(OFS_CTL_B, 16'h006E);
        core_count <= 16'h2468;
        pins.pulse(1'b1);
        rd_chk(OFS_CNT_B, 16'h2468);
        $display("test capture done");
    endtask : t_capture

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    initial begin
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        core_count = 16'h0000;
        core_overflow = 1'b0;
        core_toggle_latch = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        t_timer;
        t_counter;
        t_gate;
        t_chain;
        t_reload;
        t_capture;
        print_verdict;
    end

    // watchdog far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        print_verdict;
    end
endmodule : tb
